// ==== hw/cco_pkg.sv ====
// Constants and carriers for the counter compare output block
// Operation
// - 32-bit or gated mode: reaching 0x80000000 sets or clears first output.
// - Overflow after the threshold returns the output to its earlier level.
// - Single counter mode: second output follows counter bit 15.
// - Dual 16-bit mode: each counter sets or clears its own output at 0x8000.
// - Feature 0x02AC means dual counters, edge load, hold bit loads counter two.
// - Load request with function enable loads the preset from output data.
// - After load, status reads 0x28 and first output is high while counting.
// - At threshold first output goes low and status returns to zero.
// - Standard image: status byte plus four data bytes, order and padding set.
// - Little-endian unaligned: status byte first, then D0 to D3 ascending.
// - Alternative image: four bytes, five word-aligned, six with register-mode byte added.
// - Feature bits 4 to 7 enable set/clear of first, then second output.
// - While a function enable is set its direct drive bit is ignored.
package cco_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_FEATURE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_PRESET = 8'h08;
	localparam logic [7:0] ADDR_IMG_CFG = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;
	localparam logic [7:0] ADDR_IMG_LO = 8'h18;
	localparam logic [7:0] ADDR_IMG_HI = 8'h1c;
	localparam logic [7:0] ADDR_IMG_LEN = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h28;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h2c;
	localparam logic [7:0] ADDR_REGMODE = 8'h30;
	// Reset value and example values
	localparam logic [15:0] FEATURE_RESET = 16'h0100;
	localparam logic [15:0] FEAT_DUAL_EXAMPLE = 16'h02ac;
	localparam logic [7:0] CTRL_LOAD_RUN = 8'h22;
	localparam logic [7:0] STATUS_RUNNING = 8'h28;
	// Feature register fields
	localparam int FEAT_ALT_FORMAT = 1;
	localparam int FEAT_HOLD_LOADS_SECOND = 2;
	localparam int FEAT_EDGE_LOAD = 3;
	localparam int FEAT_SET_FIRST = 4;
	localparam int FEAT_CLR_FIRST = 5;
	localparam int FEAT_SET_SECOND = 6;
	localparam int FEAT_CLR_SECOND = 7;
	localparam int FEAT_MODE_LSB = 8;
	localparam int FEAT_DOWN = 11;
	localparam logic [2:0] MODE_CODE_UPDOWN = 3'h1;
	localparam logic [2:0] MODE_CODE_DUAL = 3'h2;
	localparam logic [2:0] MODE_CODE_GATE_LO = 3'h4;
	localparam logic [2:0] MODE_CODE_GATE_HI = 3'h5;
	// Process control byte fields
	localparam int CTRL_SECOND_EN = 0;
	localparam int CTRL_FIRST_EN = 1;
	localparam int CTRL_SECOND_DRV = 2;
	localparam int CTRL_FIRST_DRV = 3;
	localparam int CTRL_HOLD = 4;
	localparam int CTRL_LOAD = 5;
	// Thresholds
	localparam int CNT_HALF_W = 16;
	localparam logic [15:0] THR_HALF = 16'h8000;
	localparam logic [31:0] THR_FULL = 32'h8000_0000;
	// Process image sizes
	localparam int IMG_BYTES = 6;
	localparam int STD_DATA_BYTES = 4;
	localparam int ALT_DATA_BYTES = 3;
	localparam logic [2:0] STD_IMG_LEN = 3'h5;
	// Interrupt event bits
	localparam int IRQ_W = 4;
	localparam int IRQ_FIRST_HIT = 0;
	localparam int IRQ_SECOND_HIT = 1;
	localparam int IRQ_OVERFLOW = 2;
	localparam int IRQ_LOADED = 3;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_UPDOWN, MODE_DUAL, MODE_GATE_LO, MODE_GATE_HI
	} cco_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cco_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cco_apb_rsp_t;

	typedef struct packed {
		logic complete_eval;
		logic big_endian;
		logic word_align;
	} cco_img_cfg_t;
endpackage : cco_pkg

// ==== hw/cco_counter.sv ====
// Loadable up/down counter slice with wrap detection
`timescale 1ns/10ps
module cco_counter import cco_pkg::*; #(
	parameter int WIDTH = CNT_HALF_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic step,
	input wire logic up,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	// Count
	output logic [WIDTH-1:0] value,
	output logic [WIDTH-1:0] value_next,
	output logic wrap
);
	typedef struct packed {
		logic [WIDTH-1:0] value;
	} cco_cnt_state_t;

	cco_cnt_state_t state_reg;
	cco_cnt_state_t state_next;

	if (WIDTH < 2) begin : g_check
		$error("cco_counter needs WIDTH of at least 2");
	end

	always_comb begin
		state_next = state_reg;
		// Load beats counting so a preset is never off by one
		if (load) begin
			state_next.value = load_value;
		end else if (step) begin
			state_next.value = up ? state_reg.value + 1'b1
				: state_reg.value - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign value = state_reg.value;
	assign value_next = state_next.value;
	assign wrap = step & ~load & (up ? &state_reg.value : ~|state_reg.value);
endmodule : cco_counter

// ==== hw/cco_image.sv ====
// Process image packer for the counter data and control/status bytes
`timescale 1ns/10ps
module cco_image import cco_pkg::*; (
	// Format selection
	input wire logic alt_format,
	input wire cco_img_cfg_t cfg,
	// Bytes to place
	input wire logic [7:0] regmode_byte,
	input wire logic [7:0] process_byte,
	input wire logic [31:0] counter_data,
	// Packed image, byte 0 at the lowest offset
	output logic [IMG_BYTES*8-1:0] image,
	output logic [2:0] image_len
);
	always_comb begin
		int n;
		int nd;
		n = 0;
		nd = alt_format ? ALT_DATA_BYTES : STD_DATA_BYTES;
		image = '0;
		if (alt_format && cfg.complete_eval) begin
			image[7:0] = regmode_byte;
			n = 1;
		end
		image[8*n +: 8] = process_byte;
		n = n + 1;
		if ((cfg.word_align && n % 2 == 1)
			|| (alt_format && cfg.complete_eval)) begin
			n = n + 1;
		end
		for (int i = 0; i < STD_DATA_BYTES; i++) begin
			if (i < nd) begin
				image[8*(n+i) +: 8] = cfg.big_endian
					? counter_data[8*(nd-1-i) +: 8] : counter_data[8*i +: 8];
			end
		end
		image_len = 3'(n + nd);
	end
endmodule : cco_image

// ==== hw/cco_top.sv ====
// Counter with threshold driven outputs, APB registers and process image
`timescale 1ns/10ps
module cco_top import cco_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register bus
	input wire cco_apb_req_t apb_req,
	output cco_apb_rsp_t apb_rsp,
	// Field inputs
	input wire logic count_in,
	input wire logic vr_in,
	// Field outputs
	output logic first_output,
	output logic second_output,
	// Process data towards the coupler
	output logic [7:0] process_status_byte,
	output logic [IMG_BYTES*8-1:0] process_image,
	output logic [2:0] process_image_len,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		logic [15:0] feature;
		logic [7:0] ctrl;
		logic [31:0] preset;
		cco_img_cfg_t img_cfg;
		logic [7:0] regmode_ctst;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic count_prev;
		logic vr_prev;
		logic load_prev;
		logic hold_prev;
		logic load_accepted_flag;
		logic [1:0] lvl;
		logic [1:0] prior;
		logic [1:0] fired;
		logic [7:0] status;
		logic [IMG_BYTES*8-1:0] image;
		logic [2:0] img_len;
		cco_apb_rsp_t rsp;
		logic irq;
	} cco_top_state_t;

	cco_top_state_t s;
	cco_top_state_t n;

	cco_mode_t mode;
	logic single;
	logic dual;
	logic count_edge;
	logic vr_edge;
	logic gate_ok;
	logic counter_hold_request;
	logic hold_active;
	logic load0;
	logic load1;
	logic lo_step;
	logic lo_up;
	logic hi_step;
	logic hi_up;
	logic hi_load;
	logic lo_wrap;
	logic hi_wrap;
	logic [15:0] lo_val;
	logic [15:0] lo_next;
	logic [15:0] hi_val;
	logic [15:0] hi_next;
	logic [1:0] en;
	logic [1:0] setf;
	logic [1:0] clrf;
	logic [1:0] arr;
	logic [1:0] ovf;
	logic [1:0] ld;
	logic [1:0] drv;
	logic [1:0] fire;
	logic [IRQ_W-1:0] irq_evt;
	logic [IRQ_W-1:0] irq_clr;
	logic [7:0] status_next;
	logic [IMG_BYTES*8-1:0] image_c;
	logic [2:0] img_len_c;
	logic acc;
	logic wr_done;
	logic first_output_function_enable;
	logic second_output_function_enable;
	logic first_output_direct_drive;
	logic second_output_direct_drive;

	// Mode decode; unused codes leave the counter idle
	always_comb begin
		unique case (s.feature[FEAT_MODE_LSB +: 3])
			MODE_CODE_UPDOWN: mode = MODE_UPDOWN;
			MODE_CODE_DUAL: mode = MODE_DUAL;
			MODE_CODE_GATE_LO: mode = MODE_GATE_LO;
			MODE_CODE_GATE_HI: mode = MODE_GATE_HI;
			default: mode = MODE_OFF;
		endcase
	end

	assign single = mode == MODE_UPDOWN || mode == MODE_GATE_LO
		|| mode == MODE_GATE_HI;
	assign dual = mode == MODE_DUAL;
	assign count_edge = count_in & ~s.count_prev;
	assign vr_edge = vr_in & ~s.vr_prev;
	assign gate_ok = mode == MODE_GATE_LO ? vr_in
		: mode == MODE_GATE_HI ? ~vr_in : 1'b1;
	assign first_output_function_enable = s.ctrl[CTRL_FIRST_EN];
	assign second_output_function_enable = s.ctrl[CTRL_SECOND_EN];
	assign first_output_direct_drive = s.ctrl[CTRL_FIRST_DRV];
	assign second_output_direct_drive = s.ctrl[CTRL_SECOND_DRV];
	assign counter_hold_request = s.ctrl[CTRL_HOLD];

	// in dual mode with the hold-loads-second feature bit set, hold bit turns into the second counter's load
	assign hold_active = counter_hold_request
		& ~(dual & s.feature[FEAT_HOLD_LOADS_SECOND]);
	assign load0 = s.feature[FEAT_EDGE_LOAD]
		? s.ctrl[CTRL_LOAD] & ~s.load_prev : s.ctrl[CTRL_LOAD];
	assign load1 = dual & s.feature[FEAT_HOLD_LOADS_SECOND]
		& (s.feature[FEAT_EDGE_LOAD]
		? counter_hold_request & ~s.hold_prev : counter_hold_request);

	// Low half is counter one; in single mode it carries into the high half
	assign lo_step = (single | dual) & count_edge & gate_ok & ~hold_active;
	assign lo_up = dual | ~s.feature[FEAT_DOWN];
	assign hi_step = dual ? vr_edge & ~hold_active : lo_wrap;
	assign hi_up = lo_up;
	assign hi_load = dual ? load1 : load0;

	cco_counter #(.WIDTH(CNT_HALF_W)) u_cnt_lo (
		.ref_clk(ref_clk),
		.reset(reset),
		.step(lo_step),
		.up(lo_up),
		.load(load0),
		.load_value(s.preset[15:0]),
		.value(lo_val),
		.value_next(lo_next),
		.wrap(lo_wrap)
	);

	cco_counter #(.WIDTH(CNT_HALF_W)) u_cnt_hi (
		.ref_clk(ref_clk),
		.reset(reset),
		.step(hi_step),
		.up(hi_up),
		.load(hi_load),
		.load_value(s.preset[31:16]),
		.value(hi_val),
		.value_next(hi_next),
		.wrap(hi_wrap)
	);

	assign arr[0] = single ? lo_step & ({hi_next, lo_next} == THR_FULL)
		: dual & lo_step & (lo_next == THR_HALF);
	assign arr[1] = dual & hi_step & (hi_next == THR_HALF);
	// overflow of the counter that drives each output
	assign ovf[0] = single ? hi_wrap : dual & lo_wrap;
	assign ovf[1] = dual & hi_wrap;
	assign ld[0] = load0;
	assign ld[1] = hi_load;
	assign en[0] = first_output_function_enable;
	assign en[1] = second_output_function_enable;
	assign drv[0] = first_output_direct_drive;
	assign drv[1] = second_output_direct_drive;

	for (genvar g = 0; g < 2; g++) begin : g_chan
		assign setf[g] = s.feature[FEAT_SET_FIRST + 2*g];
		assign clrf[g] = s.feature[FEAT_CLR_FIRST + 2*g];
		assign fire[g] = en[g] & ~ld[g] & arr[g] & ~s.fired[g]
			& (setf[g] | clrf[g]);
	end

	cco_image u_image (
		.alt_format(s.feature[FEAT_ALT_FORMAT]),
		.cfg(s.img_cfg),
		.regmode_byte(s.regmode_ctst),
		.process_byte(s.status),
		.counter_data({hi_val, lo_val}),
		.image(image_c),
		.image_len(img_len_c)
	);

	assign acc = apb_req.psel & apb_req.penable;
	assign wr_done = acc & s.rsp.pready & apb_req.pwrite;
	assign irq_clr = wr_done && apb_req.paddr == ADDR_IRQ_CLR
		? apb_req.pwdata[IRQ_W-1:0] : '0;
	assign irq_evt = {ld[0] & en[0], (ovf[0] & s.fired[0])
		| (ovf[1] & s.fired[1]), fire[1], fire[0]};

	always_comb begin
		n = s;
		n.count_prev = count_in;
		n.vr_prev = vr_in;
		n.load_prev = s.ctrl[CTRL_LOAD];
		n.hold_prev = counter_hold_request;

		for (int i = 0; i < 2; i++) begin
			if (!en[i]) begin
				// direct drive only while the function is off
				n.lvl[i] = drv[i];
				n.fired[i] = 1'b0;
			end else if (ld[i]) begin
				// Arm: sit at the level opposite to the threshold action
				n.lvl[i] = clrf[i] & ~setf[i];
				n.fired[i] = 1'b0;
			end else if (fire[i]) begin
				n.prior[i] = s.lvl[i];
				n.lvl[i] = setf[i];
				n.fired[i] = 1'b1;
			end else if (ovf[i] && s.fired[i]) begin
				n.lvl[i] = s.prior[i];
				n.fired[i] = 1'b0;
			end
		end
		// second output mirrors counter bit 15
		if (single && en[1]) begin
			n.lvl[1] = lo_next[15];
		end

		// load accepted until the threshold is reached
		if (ld[0]) begin
			n.load_accepted_flag = 1'b1;
		end else if (fire[0]) begin
			// load-accepted status bit clears when the first output fires
			n.load_accepted_flag = 1'b0;
		end

		// status built from the next output levels
		status_next = {2'h0, n.load_accepted_flag, hold_active, n.lvl[0],
			n.lvl[1], vr_in, count_in};
		n.status = status_next;
		n.image = image_c;
		n.img_len = img_len_c;

		// Set wins over a clear in the same cycle
		n.irq_stat = (s.irq_stat & ~irq_clr) | irq_evt;
		n.irq = |(n.irq_stat & s.irq_en);

		// Two-cycle access: pready rises on the second access cycle
		n.rsp.pready = acc & ~s.rsp.pready;
		n.rsp.pslverr = 1'b0;
		n.rsp.prdata = '0;
		if (acc && !s.rsp.pready) begin
			case (apb_req.paddr)
				ADDR_FEATURE: n.rsp.prdata = {16'h0, s.feature};
				ADDR_CTRL: n.rsp.prdata = {24'h0, s.ctrl};
				ADDR_PRESET: n.rsp.prdata = s.preset;
				ADDR_IMG_CFG: n.rsp.prdata = {29'h0, s.img_cfg};
				ADDR_STATUS: n.rsp.prdata = {24'h0, s.status};
				ADDR_COUNT: n.rsp.prdata = {hi_val, lo_val};
				ADDR_IMG_LO: n.rsp.prdata = s.image[31:0];
				ADDR_IMG_HI: n.rsp.prdata = {16'h0, s.image[47:32]};
				ADDR_IMG_LEN: n.rsp.prdata = {29'h0, s.img_len};
				ADDR_IRQ_STAT: n.rsp.prdata = {28'h0, s.irq_stat};
				ADDR_IRQ_EN: n.rsp.prdata = {28'h0, s.irq_en};
				ADDR_IRQ_CLR: n.rsp.prdata = '0;
				ADDR_REGMODE: n.rsp.prdata = {24'h0, s.regmode_ctst};
				default: n.rsp.pslverr = 1'b1;
			endcase
		end
		if (wr_done) begin
			case (apb_req.paddr)
				ADDR_FEATURE: n.feature = apb_req.pwdata[15:0];
				ADDR_CTRL: n.ctrl = apb_req.pwdata[7:0];
				ADDR_PRESET: n.preset = apb_req.pwdata;
				ADDR_IMG_CFG: n.img_cfg = apb_req.pwdata[2:0];
				ADDR_IRQ_EN: n.irq_en = apb_req.pwdata[IRQ_W-1:0];
				ADDR_REGMODE: n.regmode_ctst = apb_req.pwdata[7:0];
				default: n.feature = s.feature;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.feature <= FEATURE_RESET;
		end else begin
			s <= n;
		end
	end

	assign apb_rsp = s.rsp;
	assign first_output = s.lvl[0];
	assign second_output = s.lvl[1];
	assign process_status_byte = s.status;
	assign process_image = s.image;
	assign process_image_len = s.img_len;
	assign irq = s.irq;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	thr_set_a: assert property (
		single && en[0] && !ld[0] && arr[0] && !s.fired[0] && setf[0]
		|=> first_output && s.fired[0])
		else $error("first output not set at full threshold");
	// Watched on counter two; both outputs share one loop body
	ovf_restore_a: assert property (
		en[1] && !ld[1] && !arr[1] && ovf[1] && s.fired[1]
		|=> second_output == $past(s.prior[1]) && !s.fired[1])
		else $error("overflow did not restore second output");
	bit15_follow_a: assert property (
		$past(single && en[1]) |-> second_output == lo_val[15])
		else $error("second output not following bit 15");
	dual_clear_a: assert property (
		dual && en[1] && !ld[1] && arr[1] && !s.fired[1] && clrf[1]
		&& !setf[1] |=> !second_output)
		else $error("second counter did not clear its output");
	example_feat_a: assert property (
		s.feature == FEAT_DUAL_EXAMPLE |-> dual && !hold_active
		&& (load1 == (counter_hold_request && !s.hold_prev)))
		else $error("example feature value decoded wrongly");
	load_value_a: assert property (
		single && load0 |=> {hi_val, lo_val} == $past(s.preset))
		else $error("counter not loaded from preset");
	running_st_a: assert property (
		ld[0] && en[0] && clrf[0] && !setf[0] && !hold_active
		&& !vr_in && !count_in && !n.lvl[1]
		|=> first_output && process_status_byte == STATUS_RUNNING)
		else $error("running status not reported after load");
	full_status_a: assert property (
		fire[0] && clrf[0] && !setf[0]
		|=> !first_output && !process_status_byte[5])
		else $error("threshold did not drop output and status");
	// Image register still holds its reset value on the release edge
	std_len_a: assert property (
		!reset && !s.feature[FEAT_ALT_FORMAT] && !s.img_cfg.word_align
		|=> process_image_len == STD_IMG_LEN)
		else $error("standard image length wrong");
	le_order_a: assert property (
		!s.feature[FEAT_ALT_FORMAT] && s.img_cfg == '0
		|=> process_image[7:0] == $past(s.status)
		&& process_image[15:8] == $past(lo_val[7:0]))
		else $error("little-endian image order wrong");
	alt_len_a: assert property (
		s.feature[FEAT_ALT_FORMAT] && !s.img_cfg.word_align
		|=> process_image_len
		== ($past(s.img_cfg.complete_eval) ? 3'h6 : 3'h4))
		else $error("alternative image length wrong");
	direct_ignore_a: assert property (
		en[0] && !ld[0] && !fire[0] && !ovf[0]
		|=> first_output == $past(first_output))
		else $error("direct drive leaked while function enabled");
	status_sync_a: assert property (
		process_status_byte[3] == first_output
		&& process_status_byte[2] == second_output)
		else $error("status output bits out of step");

	fire_first_c: cover property (fire[0] ##[1:50] ovf[0]);
	load_run_c: cover property (ld[0] && s.ctrl == CTRL_LOAD_RUN);
	irq_raise_c: cover property (!irq ##1 irq);
endmodule : cco_top

// ==== tb/cco_field_model.sv ====
// Field side model: pulse source for the count and gate inputs
`timescale 1ns/10ps
module cco_field_model (
	// Clock
	input wire logic ref_clk,
	// Field inputs of the block
	output logic count_in,
	output logic vr_in
);
	initial begin
		count_in = 1'b0;
		vr_in = 1'b0;
	end

	// One high cycle then one low, so every rise is seen as a count
	task automatic pulse(input logic on_vr, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			if (on_vr) begin
				vr_in <= 1'b1;
			end else begin
				count_in <= 1'b1;
			end
			@(posedge ref_clk);
			count_in <= 1'b0;
			vr_in <= 1'b0;
		end
		// Count and irq land on the edge that samples the rise; image one edge later
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : pulse
endmodule : cco_field_model

// ==== tb/testbench.sv ====
// Self-checking bench for the counter compare output block
`timescale 1ns/10ps
`define CHECK_EQ(what, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("[FAIL] %s expected %h seen %h", what, exp, got); \
	end \
end
module testbench;
	import cco_pkg::*;
	logic ref_clk;
	logic reset;
	cco_apb_req_t apb_req;
	cco_apb_rsp_t apb_rsp;
	logic count_in, vr_in, first_output, second_output, irq;
	logic [7:0] process_status_byte;
	logic [IMG_BYTES*8-1:0] process_image;
	logic [2:0] process_image_len;
	int n_errors, cmp_count;
	logic [31:0] rd;
	logic err;

	cco_top cco_top_i (.ref_clk(ref_clk), .reset(reset),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .count_in(count_in),
		.vr_in(vr_in), .first_output(first_output),
		.second_output(second_output),
		.process_status_byte(process_status_byte),
		.process_image(process_image),
		.process_image_len(process_image_len), .irq(irq));
	cco_field_model cco_field_model_i (.ref_clk(ref_clk),
		.count_in(count_in), .vr_in(vr_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// Setup, access, then hold until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (apb_rsp.pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			$display("[FAIL] apb pready expected 1 seen 0");
			final_report();
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		`CHECK_EQ(what, exp, rd)
	endtask : rdchk

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic done(input string what);
		$display("test %s finished, mismatches so far %0d", what, n_errors);
	endtask : done

	task automatic t_reset;
		rdchk("feature reset", ADDR_FEATURE, 32'h0000_0100);
		rdchk("status reset", ADDR_STATUS, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		`CHECK_EQ("unmapped error", 1'b1, err)
		`CHECK_EQ("unmapped data", 32'h0, rd)
		done("reset");
	endtask : t_reset

	task automatic t_direct;
		wr(ADDR_CTRL, 32'h08);
		settle(1);
		`CHECK_EQ("direct first", 1'b1, first_output)
		`CHECK_EQ("direct state bit", 1'b1, process_status_byte[3])
		wr(ADDR_CTRL, 32'h00);
		settle(1);
		`CHECK_EQ("direct first off", 1'b0, first_output)
		done("direct");
	endtask : t_direct

	task automatic t_single;
		wr(ADDR_FEATURE, 32'h0110);
		wr(ADDR_PRESET, 32'h7fff_fffe);
		wr(ADDR_CTRL, 32'h23);
		// Drive bit set while armed must be ignored
		wr(ADDR_CTRL, 32'h0b);
		settle(1);
		`CHECK_EQ("armed first", 1'b0, first_output)
		`CHECK_EQ("bit15 second", 1'b1, second_output)
		cco_field_model_i.pulse(1'b0, 2);
		`CHECK_EQ("full thr first", 1'b1, first_output)
		`CHECK_EQ("bit15 low second", 1'b0, second_output)
		`CHECK_EQ("state first", 1'b1, process_status_byte[3])
		rdchk("count", ADDR_COUNT, THR_FULL);
		settle(1);
		// Load flag dropped at the hit, first output high
		`CHECK_EQ("img status", 8'h08, process_image[7:0])
		`CHECK_EQ("img data", THR_FULL, process_image[39:8])
		`CHECK_EQ("img len", STD_IMG_LEN, process_image_len)
		done("single");
	endtask : t_single

	task automatic t_irq;
		`CHECK_EQ("irq masked", 1'b0, irq)
		wr(ADDR_IRQ_EN, 32'h1);
		settle(2);
		`CHECK_EQ("irq on", 1'b1, irq)
		wr(ADDR_IRQ_CLR, 32'hf);
		settle(2);
		`CHECK_EQ("irq cleared", 1'b0, irq)
		rdchk("irq status", ADDR_IRQ_STAT, 32'h0);
		done("irq");
	endtask : t_irq

	task automatic t_dual;
		wr(ADDR_FEATURE, {16'h0, FEAT_DUAL_EXAMPLE});
		rdchk("feature dual", ADDR_FEATURE, 32'h0000_02ac);
		wr(ADDR_PRESET, 32'h0000_7ffd);
		wr(ADDR_CTRL, {24'h0, CTRL_LOAD_RUN});
		settle(1);
		`CHECK_EQ("loaded first", 1'b1, first_output)
		`CHECK_EQ("status load", STATUS_RUNNING, process_status_byte)
		wr(ADDR_CTRL, 32'h02);
		settle(1);
		`CHECK_EQ("status run", STATUS_RUNNING, process_status_byte)
		cco_field_model_i.pulse(1'b0, 2);
		`CHECK_EQ("below thr", 1'b1, first_output)
		cco_field_model_i.pulse(1'b0, 1);
		`CHECK_EQ("full first", 1'b0, first_output)
		`CHECK_EQ("full status", 8'h00, process_status_byte)
		// Counter two still holds the count left by the single test
		rdchk("count one", ADDR_COUNT, 32'h8000_8000);
		wr(ADDR_CTRL, {24'h0, CTRL_LOAD_RUN});
		settle(1);
		`CHECK_EQ("reload first", 1'b1, first_output)
		wr(ADDR_CTRL, 32'h03);
		wr(ADDR_PRESET, 32'h7fff_7fff);
		// Hold bit is the load of counter two under this feature value
		wr(ADDR_CTRL, 32'h13);
		settle(1);
		`CHECK_EQ("armed second", 1'b1, second_output)
		cco_field_model_i.pulse(1'b1, 1);
		`CHECK_EQ("second hit", 1'b0, second_output)
		`CHECK_EQ("first kept", 1'b1, first_output)
		// Full wrap of counter two takes 32768 counts
		cco_field_model_i.pulse(1'b1, 32768);
		`CHECK_EQ("overflow second", 1'b1, second_output)
		`CHECK_EQ("irq dual", 1'b1, irq)
		rdchk("irq events", ADDR_IRQ_STAT, 32'hf);
		done("dual");
	endtask : t_dual

	task automatic t_alt;
		wr(ADDR_FEATURE, 32'h0102);
		settle(2);
		`CHECK_EQ("alt len", 3'h4, process_image_len)
		wr(ADDR_REGMODE, 32'h5a);
		wr(ADDR_IMG_CFG, 32'h4);
		settle(2);
		`CHECK_EQ("alt full len", 3'h6, process_image_len)
		`CHECK_EQ("alt reg byte", 8'h5a, process_image[7:0])
		// Standard image, word aligned and big-endian; count is 0x00007ffd
		wr(ADDR_FEATURE, 32'h0100);
		wr(ADDR_IMG_CFG, 32'h3);
		settle(2);
		`CHECK_EQ("aligned len", 3'h6, process_image_len)
		`CHECK_EQ("aligned pad", 8'h00, process_image[15:8])
		`CHECK_EQ("be data", 32'hfd7f_0000, process_image[47:16])
		done("alt");
	endtask : t_alt

	initial begin
		n_errors = 0;
		cmp_count = 0;
		apb_req = '0;
		reset = 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_direct();
		t_single();
		t_irq();
		t_dual();
		t_alt();
		final_report();
	end
endmodule : testbench
